// *** shared/dac_corr_pkg.sv ***
// constants and types shared by the gain/offset correction datapath
package dac_corr_pkg;

    // ------------------------------------------------------------
    // resolution and channel count (wide sixteen-channel build)
    // ------------------------------------------------------------
    // the narrow build uses 12 bits, 0xffe, 0x800; the eight-channel
    // build uses 8 channels and 3 select bits
    localparam int RES_BITS = 14;
    localparam int CHANNELS = 16;
    localparam int CHAN_BITS = 4;
    localparam int PROD_BITS = 2 * RES_BITS + 1;
    localparam int SUM_BITS = RES_BITS + 3;

    // ------------------------------------------------------------
    // values after reset, midscale, full scale and gain bias
    // ------------------------------------------------------------
    localparam logic [RES_BITS-1:0] GAIN_RESET = 14'h3ffe;
    localparam logic [RES_BITS-1:0] TRIM_RESET = 14'h2000;
    localparam logic [RES_BITS-1:0] CODE_RESET = 14'h0000;
    localparam logic [RES_BITS-1:0] MIDSCALE = 14'h2000;
    localparam logic [RES_BITS-1:0] CODE_MAX = 14'h3fff;
    localparam logic [RES_BITS:0] GAIN_BIAS = 15'h0002;

    // ------------------------------------------------------------
    // write target select and engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SEL_NONE = 2'b00,
        SEL_GAIN = 2'b01,
        SEL_TRIM = 2'b10,
        SEL_CODE = 2'b11
    } reg_sel_type;

    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_CALC = 1'b1
    } engine_state_type;

endpackage

// *** verilog/corr_unit.sv ***
// two-stage multiply, shift, add and saturate unit for one code
`timescale 1ns/100ps
`default_nettype none
module corr_unit
    import dac_corr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [RES_BITS-1:0] i_requested_code,
    input wire logic [RES_BITS-1:0] i_gain,
    input wire logic [RES_BITS-1:0] i_trim,
    output logic o_done,
    output logic [RES_BITS-1:0] o_trimmed_code
);

    logic [PROD_BITS-1:0] product;
    logic [RES_BITS-1:0] trim_hold;
    logic stage1;
    logic [RES_BITS:0] gain_term;
    logic [SUM_BITS-1:0] sum;

    // full-width product so nothing is lost before the shift
    assign gain_term = {1'b0, i_gain} + GAIN_BIAS;
    assign sum = SUM_BITS'(product[PROD_BITS-1:RES_BITS])
                 + SUM_BITS'(trim_hold)
                 - SUM_BITS'(MIDSCALE);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            product <= '0;
            trim_hold <= TRIM_RESET;
            stage1 <= 1'b0;
        end
        else
        begin
            stage1 <= i_start;
            if (i_start)
            begin
                product <= PROD_BITS'(i_requested_code) *
                           PROD_BITS'(gain_term);
                trim_hold <= i_trim;
            end
        end
    end

    // clamp instead of wrapping; msb of sum is the sign
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_done <= 1'b0;
            o_trimmed_code <= CODE_RESET;
        end
        else
        begin
            o_done <= stage1;
            if (stage1)
            begin
                if (sum[SUM_BITS-1])
                    o_trimmed_code <= CODE_RESET;
                else if (sum[SUM_BITS-2:RES_BITS] != '0)
                    o_trimmed_code <= CODE_MAX;
                else
                    o_trimmed_code <= sum[RES_BITS-1:0];
            end
        end
    end

endmodule
`default_nettype wire

// *** verilog/dac_gain_offset_correction.sv ***
// per-channel gain/offset correction with double-buffered dac registers
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - code is (m+2)/2^n times input plus c-midscale
// - resolution 14 or 12 bits, operands n bits
// - gain resets to all ones, lsb zero
// - gain lsb always forced to zero
// - offset trim resets to midscale
// - sixteen or eight channels served
// - each channel owns independent gain and offset
// - double buffer, load strobe updates all together
// - output code is straight binary tap select
// - busy low while calculating, writes queued
// - load during busy remembered, applied afterwards
module dac_gain_offset_correction
    import dac_corr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic [CHAN_BITS-1:0] i_wr_chan,
    input wire logic [1:0] i_wr_sel,
    input wire logic [RES_BITS-1:0] i_wr_data,
    input wire logic i_load_outputs_n,
    output logic o_busy_n,
    output logic [CHANNELS*RES_BITS-1:0] o_dac_code
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [CHAN_BITS-1:0] lowest_set(
        input logic [CHANNELS-1:0] vec
    );
        logic [CHAN_BITS-1:0] idx;
        idx = '0;
        for (int k = CHANNELS - 1; k >= 0; k--)
        begin
            if (vec[k])
                idx = CHAN_BITS'(k);
        end
        return idx;
    endfunction

    function automatic logic hits(
        input logic en,
        input logic [CHAN_BITS-1:0] chan,
        input logic [1:0] sel,
        input logic [CHAN_BITS-1:0] who,
        input reg_sel_type kind
    );
        return en && (chan == who) && (reg_sel_type'(sel) == kind);
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [RES_BITS-1:0] requested_code [CHANNELS];
    logic [RES_BITS-1:0] gain [CHANNELS];
    logic [RES_BITS-1:0] trim [CHANNELS];
    logic [RES_BITS-1:0] trimmed_code [CHANNELS];
    logic [CHANNELS-1:0] dirty;

    engine_state_type state;
    logic [CHAN_BITS-1:0] calc_chan;
    logic launch;
    logic calc_done;
    logic [RES_BITS-1:0] calc_result;
    logic busy_now;
    logic load_prev;
    logic load_pending;
    logic load_fall;
    logic apply_load;
    logic [CHAN_BITS-1:0] pick;

    assign launch = (state == ST_IDLE) && (dirty != '0);
    assign busy_now = (dirty != '0) || (state == ST_CALC);
    assign load_fall = load_prev && !i_load_outputs_n;
    assign apply_load = (load_pending || load_fall) && !busy_now;

    // ------------------------------------------------------------
    // per-channel registers
    // ------------------------------------------------------------
    // a write lands at once and marks the channel for recalculation,
    // so writes during a calculation are queued, never dropped
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_chan
            localparam logic [CHAN_BITS-1:0] ME = CHAN_BITS'(g);
            logic hit_code;
            logic hit_gain;
            logic hit_trim;
            assign hit_code = hits(i_wr_en, i_wr_chan, i_wr_sel, ME, SEL_CODE);
            assign hit_gain = hits(i_wr_en, i_wr_chan, i_wr_sel, ME, SEL_GAIN);
            assign hit_trim = hits(i_wr_en, i_wr_chan, i_wr_sel, ME, SEL_TRIM);

            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    requested_code[g] <= CODE_RESET;
                    gain[g] <= GAIN_RESET;
                    trim[g] <= TRIM_RESET;
                end
                else
                begin
                    if (hit_code)
                        requested_code[g] <= i_wr_data;
                    if (hit_gain)
                        gain[g] <= {i_wr_data[RES_BITS-1:1], 1'b0};
                    if (hit_trim)
                        trim[g] <= i_wr_data;
                end
            end

            // a new write wins over the clear of the same cycle; only the
            // channel handed to the unit is cleared, so a channel re-marked
            // during its own calculation keeps its mark and waits its turn
            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    dirty[g] <= 1'b0;
                else
                    dirty[g] <= hit_code || hit_gain || hit_trim ||
                                (dirty[g] && !(launch && pick == ME));
            end

            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    trimmed_code[g] <= CODE_RESET;
                else if (calc_done && calc_chan == ME)
                    trimmed_code[g] <= calc_result;
            end

            // all dac registers copy their staged result in one edge
            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    o_dac_code[g*RES_BITS +: RES_BITS] <= CODE_RESET;
                else if (apply_load)
                    o_dac_code[g*RES_BITS +: RES_BITS] <= trimmed_code[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // calculation engine
    // ------------------------------------------------------------
    // one shared unit walks the marked channels lowest first; this
    // trades latency for area against one multiplier per channel
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            calc_chan <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (launch)
                    begin
                        calc_chan <= lowest_set(dirty);
                        state <= ST_CALC;
                    end
                end
                ST_CALC:
                begin
                    if (calc_done)
                        state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign pick = lowest_set(dirty);

    corr_unit u_corr
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(launch),
        .i_requested_code(requested_code[pick]),
        .i_gain(gain[pick]),
        .i_trim(trim[pick]),
        .o_done(calc_done),
        .o_trimmed_code(calc_result)
    );

    // ------------------------------------------------------------
    // busy flag and load strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_busy_n <= 1'b1;
        else
            o_busy_n <= !(busy_now || launch);
    end

    // a falling load seen while busy is held until the engine drains
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_prev <= 1'b1;
            load_pending <= 1'b0;
        end
        else
        begin
            load_prev <= i_load_outputs_n;
            if (apply_load)
                load_pending <= 1'b0;
            else if (load_fall)
                load_pending <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// *** verification/dac_corr_chk.sv ***
// port assertions for the gain/offset correction datapath
`timescale 1ns/100ps
`default_nettype none
module dac_corr_chk
    import dac_corr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic [CHAN_BITS-1:0] i_wr_chan,
    input wire logic [1:0] i_wr_sel,
    input wire logic [RES_BITS-1:0] i_wr_data,
    input wire logic i_load_outputs_n,
    input wire logic o_busy_n,
    input wire logic [CHANNELS*RES_BITS-1:0] o_dac_code
);
    logic wr;
    logic load_q;
    logic seen;
    assign wr = i_wr_en && (i_wr_sel != 2'b00);
    // seen marks that some load strobe has fallen since reset
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_q <= 1'b1;
            seen <= 1'b0;
        end
        else
        begin
            load_q <= i_load_outputs_n;
            seen <= seen | (load_q & !i_load_outputs_n);
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    AST_WR_BUSY: assert property (
        wr |=> ##1 !o_busy_n)
        else $error("busy did not drop after a write");
    AST_IDLE_HOLD: assert property (
        o_busy_n && !wr && !$past(wr) |=> o_busy_n)
        else $error("busy dropped without a write");
    AST_BUSY_MIN: assert property (
        $fell(o_busy_n) |-> !o_busy_n [*3])
        else $error("calculation shorter than three cycles");
    AST_BUSY_END: assert property (
        !o_busy_n |-> ##[1:1000] o_busy_n)
        else $error("busy never returned high");
    AST_NO_UPD_BUSY: assert property (
        !o_busy_n |-> $stable(o_dac_code))
        else $error("dac code moved while busy");
    AST_CODE_CAUSE: assert property (
        $changed(o_dac_code) |-> $rose(o_busy_n) ||
        (!$past(i_load_outputs_n) && $past(i_load_outputs_n, 2)))
        else $error("dac code moved without a load");
    AST_FALL_CAUSE: assert property (
        $fell(o_busy_n) |-> $past(wr, 2))
        else $error("busy fell with no write two cycles before");
    AST_QUIET: assert property (
        !seen |-> o_dac_code == '0)
        else $error("dac code nonzero before any load");
endmodule
bind dac_gain_offset_correction dac_corr_chk chk
(
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_en(i_wr_en),
    .i_wr_chan(i_wr_chan),
    .i_wr_sel(i_wr_sel),
    .i_wr_data(i_wr_data),
    .i_load_outputs_n(i_load_outputs_n),
    .o_busy_n(o_busy_n),
    .o_dac_code(o_dac_code)
);
`default_nettype wire

// *** verification/host_model.sv ***
// host side writer: register writes and load strobe, driven on falling edge
`timescale 1ns/100ps
`default_nettype none
module host_model
    import dac_corr_pkg::*;
(
    input wire logic i_clk,
    output logic o_wr_en,
    output logic [CHAN_BITS-1:0] o_wr_chan,
    output logic [1:0] o_wr_sel,
    output logic [RES_BITS-1:0] o_wr_data,
    output logic o_load_n
);
    initial
    begin
        o_wr_en = 1'b0;
        o_wr_chan = '0;
        o_wr_sel = 2'b00;
        o_wr_data = '0;
        o_load_n = 1'b1;
    end
    // enable stays high between back-to-back writes
    task automatic put(
        input logic [CHAN_BITS-1:0] c,
        input logic [1:0] s,
        input logic [RES_BITS-1:0] d
    );
        o_wr_en = 1'b1;
        o_wr_chan = c;
        o_wr_sel = s;
        o_wr_data = d;
        @(negedge i_clk);
    endtask
    // released data shows the inverse so stale values cannot pass
    task automatic rest();
        o_wr_en = 1'b0;
        o_wr_data = ~o_wr_data;
        @(negedge i_clk);
    endtask
    task automatic strobe();
        o_load_n = 1'b0;
        @(negedge i_clk);
        o_load_n = 1'b1;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the gain/offset correction datapath
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dac_corr_pkg::*;
    localparam int VW = CHANNELS * RES_BITS;
    logic clk = 1'b0;
    logic rst_n;
    logic wr_en, load_n, busy_n;
    logic [CHAN_BITS-1:0] wr_chan;
    logic [1:0] wr_sel;
    logic [RES_BITS-1:0] wr_data;
    logic [CHANNELS*RES_BITS-1:0] dac_code, prev = '0;
    // what the dac registers should hold after the latest load
    logic [CHANNELS*RES_BITS-1:0] last_e = '0;
    logic [RES_BITS-1:0] m_gain[CHANNELS], m_trim[CHANNELS], m_code[CHANNELS];
    logic [CHANNELS*RES_BITS-1:0] expq[$];
    int mismatches = 0, n_compared = 0, cycles = 0;
    always #2.5 clk = ~clk;
    host_model host
    (
        .i_clk(clk), .o_wr_en(wr_en), .o_wr_chan(wr_chan),
        .o_wr_sel(wr_sel), .o_wr_data(wr_data), .o_load_n(load_n)
    );
    dac_gain_offset_correction DUT
    (
        .i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr_en),
        .i_wr_chan(wr_chan), .i_wr_sel(wr_sel), .i_wr_data(wr_data),
        .i_load_outputs_n(load_n), .o_busy_n(busy_n),
        .o_dac_code(dac_code)
    );
    function automatic logic [RES_BITS-1:0] rnd();
        return RES_BITS'($urandom);
    endfunction
    function automatic logic [RES_BITS-1:0] corr(input int k);
        longint v;
        v = longint'(m_code[k]) * (longint'(m_gain[k]) + 2);
        v = v >>> RES_BITS;
        v = v + longint'(m_trim[k]) - longint'(MIDSCALE);
        if (v < 0)
            v = 0;
        if (v > longint'(CODE_MAX))
            v = longint'(CODE_MAX);
        return RES_BITS'(v);
    endfunction
    task automatic check(
        input logic [CHANNELS*RES_BITS-1:0] got,
        input logic [CHANNELS*RES_BITS-1:0] exp
    );
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t value differs", $time);
        end
    endtask
    task automatic wr(
        input int k,
        input logic [1:0] s,
        input logic [RES_BITS-1:0] d
    );
        host.put(k[CHAN_BITS-1:0], s, d);
        case (s)
            2'b11: m_code[k] = d;
            2'b10: m_trim[k] = d;
            2'b01: m_gain[k] = {d[RES_BITS-1:1], 1'b0};
            default: ;
        endcase
    endtask
    task automatic load();
        logic [CHANNELS*RES_BITS-1:0] e;
        for (int k = 0; k < CHANNELS; k++)
            e[k*RES_BITS +: RES_BITS] = corr(k);
        // a load that leaves every code as it stands shows no update
        // for the watcher, so only a real change is queued
        if (e !== last_e)
            expq.push_back(e);
        last_e = e;
        host.strobe();
    endtask
    // busy falls two edges after a write, so look only after that
    task automatic wait_idle();
        repeat (3) @(negedge clk);
        for (int i = 0; i < 1000 && busy_n !== 1'b1; i++)
            @(negedge clk);
        check(VW'(busy_n), VW'(1'b1));
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // any update takes the oldest expectation; one with none queued fails
    always @(negedge clk)
    begin
        if (rst_n === 1'b1 && dac_code !== prev)
        begin
            if (expq.size() == 0)
                check(dac_code, prev);
            else
                check(dac_code, expq.pop_front());
        end
        prev = dac_code;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("CHECK FAILED %0t run timed out", $time);
            give_verdict();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        void'($urandom(32'h5e05));
        for (int k = 0; k < CHANNELS; k++)
        begin
            m_gain[k] = 14'h3ffe;
            m_trim[k] = 14'h2000;
            m_code[k] = '0;
        end
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        // default gain and trim, random codes: load lands while busy and waits for it
        for (int k = 0; k < CHANNELS; k++)
            wr(k, 2'b11, rnd());
        host.rest();
        check(VW'(busy_n), VW'(1'b0));
        load();
        wait_idle();
        // per-channel trims with saturation corners, loaded when idle
        for (int k = 0; k < CHANNELS; k++)
        begin
            wr(k, 2'b01, rnd() | 14'h0001);
            wr(k, 2'b10, rnd());
        end
        wr(0, 2'b11, 14'h3fff);
        wr(0, 2'b01, 14'h3fff);
        wr(0, 2'b10, 14'h3fff);
        wr(1, 2'b11, 14'h3fff);
        wr(1, 2'b01, 14'h0000);
        wr(1, 2'b10, 14'h0000);
        wr(2, 2'b00, 14'h1234);
        host.rest();
        wait_idle();
        load();
        repeat (20) @(negedge clk);
        for (int r = 0; r < 6; r++)
        begin
            wr(0, 2'b11, rnd());
            for (int j = 0; j < 5; j++)
                wr(int'($urandom_range(15)), 2'($urandom), rnd());
            host.rest();
            if (r[0])
                wait_idle();
            load();
            wait_idle();
            check(dac_code, last_e);
        end
        repeat (10) @(negedge clk);
        if (expq.size() != 0)
            check(dac_code, ~dac_code);
        give_verdict();
    end
endmodule
`default_nettype wire
